// [include/sece_pkg.sv]
// Purpose: shared constants and types of the serial eeprom command engine
// Assumes: 250 MHz system clock
// Notes:   offsets, fields, reset values and timing counts live here only
`default_nettype none

package sece_pkg;

	// slave address headers
	localparam logic [3:0]  HDR_ARRAY       = 4'ha;     // main array access
	localparam logic [3:0]  HDR_SPECIAL     = 4'hb;     // secure page, id, config

	// address geometry
	localparam int          ARR_AW          = 13;       // array counter width
	localparam int          MEM_AW          = 14;       // array plus secure page storage
	localparam int          SEC_AW          = 6;        // secure page offset width
	localparam int          PAGE_BITS       = 5;        // in-page bits for write wrap
	localparam logic [13:0] SEC_BASE        = 14'h2000; // secure page storage base

	// special space select, first address byte bits 2:1
	localparam logic [1:0]  SP_SECURE       = 2'h0;
	localparam logic [1:0]  SP_UID          = 2'h1;
	localparam logic [1:0]  SP_LOCK         = 2'h2;
	localparam logic [1:0]  SP_CFG          = 2'h3;

	// configuration register layout
	localparam int          CFG_WP_BIT      = 1;        // global_write_protect_bit
	localparam int          CFG_SEL_LSB     = 5;        // device_select_bit_0 position
	localparam logic [7:0]  CFG_RESET       = 8'h00;    // settable bits after power-up
	localparam logic [7:0]  CFG_UNUSED      = 8'h1d;    // bits that read as one
	localparam logic [7:0]  CFG_SETTABLE    = 8'he2;    // bits that a write stores
	localparam logic [7:0]  CFG_WP_MASK     = 8'h02;

	// lock control
	localparam logic [7:0]  LOCK_PATTERN    = 8'hff;    // data that sets the lock
	localparam int          LOCK_STATUS_BIT = 1;        // lock flag in status byte

	// internal_write_time
	localparam int          INTERNAL_WRITE_TIME_US = 5000;
	localparam int          SYS_CLK_MHZ     = 250;
	localparam int          WRITE_CYCLES_DEF = INTERNAL_WRITE_TIME_US * SYS_CLK_MHZ;

	// byte engine states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_ADR_HI,
		ST_ADR_LO,
		ST_WDATA,
		ST_RDATA
	} sece_state_e;

	// storage write port
	typedef struct packed {
		logic        we;
		logic [13:0] addr;
		logic [7:0]  data;
	} sece_wr_s;

endpackage : sece_pkg

`default_nettype wire

// [rtl/sece_mem.sv]
// Purpose: byte storage for the main array and the secure page
// Assumes: one write and one read per clock
// Notes:   read data are registered; contents start erased
`timescale 1ns/1ps
`default_nettype none

module sece_mem #(
	parameter int AW = 14,
	parameter int DW = 8
) (
	input  wire logic             clk,
	input  wire sece_pkg::sece_wr_s wr,
	input  wire logic [AW-1:0]    raddr,
	output logic [DW-1:0]         rdata
);
	import sece_pkg::*;

	logic [DW-1:0] mem [2**AW]; // storage cells

	// erased delivery state
	initial begin
		for (int i = 0; i < 2**AW; i++) begin
			mem[i] = {DW{1'b1}};
		end
	end

	// write port and registered read port
	always_ff @(posedge clk) begin
		if (wr.we) begin
			mem[wr.addr[AW-1:0]] <= wr.data[DW-1:0];
		end
		rdata <= mem[raddr];
	end

endmodule : sece_mem

`default_nettype wire

// [rtl/sece_engine.sv]
// Purpose: command engine of a two-wire serial eeprom slave
// Assumes: master drives scl and all start/stop conditions
// Notes:   scl and sda are sampled by sys_clk; sda is open drain
// What this block does (R9 is what its master does)
// [R1] header 1010 array, 1011 special spaces
// [R2] select bits read zero after power-up
// [R3] data byte acked only if writable
// [R4] lock status byte bit 1 shows lock
// [R5] byte write acks four bytes, stop writes
// [R6] no address ack during internal write
// [R7] page write wraps within 32 bytes
// [R8] low address bits load the counter
// [R9] master waits full time after config write
// [R10] secure page write uses x00x selector
// [R11] lock write uses x10x and ff
// [R12] locked secure page refuses writes
// [R13] config write sets register and select
// [R14] protect bit blocks array, secure page and lock writes
// [R15] under protect only clearing protect allowed
// [R16] read ack then send current byte
// [R17] dummy write then read loads address
// [R18] sequential read wraps at memory end
// [R19] secure page read wraps to zero
// [R20] config read forces unused bits one
// [R21] config read repeats same value
// [R22] unique id uses x01x selector
// [R23] unique id wraps after sixteen bytes
// [R24] page wrap from five low bits
// [R25] refused write starts no write cycle
`timescale 1ns/1ps
`default_nettype none

module sece_engine #(
	parameter int           WRITE_CYCLES = sece_pkg::WRITE_CYCLES_DEF,
	parameter logic [127:0] UNIQUE_ID    = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0 // arbitrary value
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	output logic            write_busy,
	output logic            page_locked,
	output logic [7:0]      config_value,
	output logic            global_write_protect_bit,
	output logic            device_select_bit_2,
	output logic            device_select_bit_1,
	output logic            device_select_bit_0
);
	import sece_pkg::*;

	localparam int BW = $clog2(WRITE_CYCLES + 1); // busy counter width

	// true when the current transfer targets special space want
	function automatic logic in_sp(input logic spc, input logic [1:0] md, input logic [1:0] want);
		return spc && (md == want);
	endfunction : in_sp

	logic [1:0]         sync1;       // first stage, read by sync2 only
	logic [1:0]         sync2;
	logic [1:0]         sync3;
	logic [1:0]         filt;        // accepted pin levels {scl, sda}
	logic [1:0]         filt_q;      // previous accepted levels
	sece_state_e        st;          // byte engine state
	logic [3:0]         cnt;         // scl rises in the byte
	logic [7:0]         shreg;       // received byte
	logic               mack;        // master acked a read byte
	logic               cur_special; // transfer uses header 1011
	logic [1:0]         spec_mode;   // special space last selected
	logic [7:0]         adr_hi;      // first address byte
	logic [ARR_AW-1:0]  arr_ptr;     // array address counter
	logic [SEC_AW-1:0]  sec_ptr;     // secure page offset
	logic [3:0]         uid_ptr;     // unique id byte index
	logic [7:0]         cfg;         // settable configuration bits
	logic               locked;      // secure page lock
	logic               wrote;       // an array, secure page or lock write was accepted this transfer
	logic               busy;        // internal write cycle running
	logic [BW-1:0]      busy_cnt;    // cycles left in the write cycle
	logic [7:0]         tx_byte;     // byte being shifted out
	logic [7:0]         mem_rdata;
	sece_wr_s           mem_wr;

	// pin conditioning: three flops, change taken when stage 2 and 3 agree
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1 <= 2'h3;
			sync2 <= 2'h3;
			sync3 <= 2'h3;
		end else begin
			sync1 <= {scl_in, sda_in};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	for (genvar gi = 0; gi < 2; gi++) begin : g_filt
		// glitch filter per pin
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				filt[gi] <= 1'b1;
			end else if (sync2[gi] == sync3[gi]) begin
				filt[gi] <= sync3[gi];
			end
		end
	end

	// previous accepted levels for edge finding
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			filt_q <= 2'h3;
		end else begin
			filt_q <= filt;
		end
	end

	// bus events
	wire scl_f     = filt[1];
	wire sda_f     = filt[0];
	wire scl_rise  = scl_f && !filt_q[1];
	wire scl_fall  = !scl_f && filt_q[1];
	wire start_ev  = scl_f && filt_q[1] && filt_q[0] && !sda_f;
	wire stop_ev   = scl_f && filt_q[1] && !filt_q[0] && sda_f;
	wire active    = (st != ST_IDLE);
	wire byte_end  = active && scl_fall && (cnt == 4'd8);
	wire ack_end   = active && scl_fall && (cnt == 4'd9);
	wire wp        = cfg[CFG_WP_BIT];

	// space decode
	wire sp_sec    = in_sp(cur_special, spec_mode, SP_SECURE);
	wire sp_uid    = in_sp(cur_special, spec_mode, SP_UID);
	wire sp_lock   = in_sp(cur_special, spec_mode, SP_LOCK);
	wire sp_cfg    = in_sp(cur_special, spec_mode, SP_CFG);

	// address byte match against header and select bits
	wire hdr_ok    = (shreg[7:4] == HDR_ARRAY) || (shreg[7:4] == HDR_SPECIAL); // R1
	wire dev_hit   = hdr_ok && (shreg[3:1] == cfg[CFG_SEL_LSB +: 3]) && !busy; // R6

	// data byte acceptance per target
	wire sec_ok    = !wp && !locked; // R12 R14
	wire data_ok   = !cur_special ? !wp : // R3 R14
		sp_sec ? sec_ok :
		sp_lock ? (sec_ok && (shreg == LOCK_PATTERN)) : // R11
		sp_cfg ? (!wp || !shreg[CFG_WP_BIT]) : // R15
		1'b0;
	wire accept    = byte_end && (st == ST_WDATA) && data_ok;

	// acknowledge decision at the end of a received byte
	wire ack_dec   = (st == ST_DEV) ? dev_hit :
		((st == ST_ADR_HI) || (st == ST_ADR_LO)) ? 1'b1 : // R5
		(st == ST_WDATA) ? data_ok : 1'b0;

	// read byte selection
	wire [7:0] uid_byte = UNIQUE_ID[{~uid_ptr, 3'h0} +: 8];
	wire [7:0] lock_byte = locked ? 8'h02 : 8'h00; // R4
	wire [7:0] rd_byte  = sp_uid ? uid_byte :
		sp_lock ? lock_byte :
		sp_cfg ? (cfg | CFG_UNUSED) : mem_rdata; // R20 R21

	// next byte goes out after address ack on read, or after master ack
	wire tx_load   = ack_end && (((st == ST_DEV) && sda_oe && shreg[0]) || ((st == ST_RDATA) && mack)); // R16

	// storage ports
	wire [MEM_AW-1:0] sec_addr = SEC_BASE + {8'h00, sec_ptr};
	wire [MEM_AW-1:0] rd_addr  = cur_special ? sec_addr : {1'b0, arr_ptr};
	assign mem_wr.we   = accept && (!cur_special || sp_sec);
	assign mem_wr.addr = rd_addr;
	assign mem_wr.data = shreg;

	sece_mem #(
		.AW    (MEM_AW),
		.DW    (8)
	) u_mem (
		.clk   (sys_clk),
		.wr    (mem_wr),
		.raddr (rd_addr),
		.rdata (mem_rdata)
	);

	// byte engine: bit count, shift, state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st          <= ST_IDLE;
			cnt         <= 4'h0;
			shreg       <= 8'h00;
			mack        <= 1'b0;
			cur_special <= 1'b0;
			spec_mode   <= SP_SECURE;
			adr_hi      <= 8'h00;
		end else if (start_ev) begin
			st  <= ST_DEV;
			cnt <= 4'h0;
		end else if (stop_ev) begin
			st  <= ST_IDLE;
			cnt <= 4'h0;
		end else if (scl_rise && active) begin
			// data bits shift in, ninth bit is the master's ack
			if (cnt < 4'd8) begin
				shreg <= {shreg[6:0], sda_f};
			end else begin
				mack <= !sda_f;
			end
			cnt <= cnt + 4'h1;
		end else if (byte_end) begin
			case (st)
				ST_DEV: begin
					cur_special <= shreg[4]; // R1
				end
				ST_ADR_HI: begin
					adr_hi <= shreg;
					if (cur_special) begin
						spec_mode <= shreg[2:1]; // R10 R11 R13 R22
					end
				end
				default: begin
				end
			endcase
		end else if (ack_end) begin
			cnt <= 4'h0;
			case (st)
				ST_DEV: begin
					if (!sda_oe) begin
						st <= ST_IDLE;
					end else if (shreg[0]) begin
						st <= ST_RDATA;
					end else begin
						st <= ST_ADR_HI;
					end
				end
				ST_ADR_HI: begin
					st <= ST_ADR_LO;
				end
				ST_ADR_LO: begin
					st <= ST_WDATA; // R17
				end
				ST_WDATA: begin
					if (!sda_oe) begin
						st <= ST_IDLE;
					end
				end
				ST_RDATA: begin
					if (!mack) begin
						st <= ST_IDLE; // R16
					end
				end
				default: begin
					st <= ST_IDLE;
				end
			endcase
		end
	end

	// address counters
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			arr_ptr <= '0;
			sec_ptr <= '0;
			uid_ptr <= 4'h0;
		end else if (byte_end && (st == ST_ADR_LO)) begin
			// second address byte loads the selected counter
			if (!cur_special) begin
				arr_ptr <= {adr_hi[4:0], shreg}; // R8
			end else if (sp_sec) begin
				sec_ptr <= shreg[SEC_AW-1:0]; // R10
			end else if (sp_uid) begin
				uid_ptr <= shreg[3:0]; // R22
			end
		end else if (mem_wr.we) begin
			// write advance stays inside the page
			if (!cur_special) begin
				arr_ptr <= {arr_ptr[ARR_AW-1:PAGE_BITS], arr_ptr[PAGE_BITS-1:0] + 5'h01}; // R7 R24
			end else begin
				sec_ptr <= {sec_ptr[SEC_AW-1:PAGE_BITS], sec_ptr[PAGE_BITS-1:0] + 5'h01}; // R7
			end
		end else if (tx_load) begin
			// read advance wraps at the end of the space
			if (!cur_special) begin
				arr_ptr <= arr_ptr + 13'h0001; // R18
			end else if (sp_sec) begin
				sec_ptr <= sec_ptr + 6'h01; // R19
			end else if (sp_uid) begin
				uid_ptr <= uid_ptr + 4'h1; // R23
			end
		end
	end

	// configuration, lock and write cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg      <= CFG_RESET; // R2
			locked   <= 1'b0;
			wrote    <= 1'b0;
			busy     <= 1'b0;
			busy_cnt <= '0;
		end else begin
			if (accept && sp_cfg) begin
				cfg <= wp ? (cfg & ~CFG_WP_MASK) : (shreg & CFG_SETTABLE); // R13 R15
			end
			if (accept && sp_lock) begin
				locked <= 1'b1; // R11
			end
			if (stop_ev) begin
				wrote <= 1'b0;
			end else if (accept && !sp_cfg) begin
				wrote <= 1'b1;
			end
			if (stop_ev && wrote) begin
				busy     <= 1'b1; // R5 R25
				busy_cnt <= BW'(WRITE_CYCLES - 1);
			end else if (busy) begin
				busy_cnt <= busy_cnt - BW'(1);
				busy     <= (busy_cnt != '0);
			end
		end
	end

	// open-drain drive: ack slots and read data bits
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sda_oe  <= 1'b0;
			tx_byte <= 8'hff;
		end else if (start_ev || stop_ev) begin
			sda_oe <= 1'b0;
		end else if (byte_end) begin
			sda_oe <= (st != ST_RDATA) && ack_dec; // R3 R6
		end else if (ack_end) begin
			tx_byte <= rd_byte;
			sda_oe  <= tx_load && !rd_byte[7];
		end else if (scl_fall && (st == ST_RDATA) && (cnt != 4'h0)) begin
			sda_oe <= !tx_byte[3'd7 - cnt[2:0]];
		end
	end

	assign sda_out                  = 1'b0;
	assign write_busy               = busy;
	assign page_locked              = locked;
	assign config_value             = cfg;
	assign global_write_protect_bit = cfg[CFG_WP_BIT];
	assign device_select_bit_2      = cfg[CFG_SEL_LSB + 2];
	assign device_select_bit_1      = cfg[CFG_SEL_LSB + 1];
	assign device_select_bit_0      = cfg[CFG_SEL_LSB];

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_wr_byte;
		byte_end && (st == ST_WDATA);
	endsequence

	sequence s_hold_busy;
		busy [*2];
	endsequence

	AST_BUSY_NOACK: assert property (byte_end && (st == ST_DEV) && busy |=> !sda_oe) // R6
		else $error("address acked during write cycle");
	AST_ADDR_ACK: assert property (byte_end && (st == ST_ADR_LO) |=> sda_oe) // R5
		else $error("address byte not acked");
	AST_PROT_NACK: assert property (s_wr_byte ##0 (wp && !cur_special) |=> !sda_oe) // R3
		else $error("protected array byte acked");
	AST_PROT_NOWRITE: assert property (wp |-> !mem_wr.we) // R14
		else $error("storage written under protect");
	AST_LOCK_NACK: assert property (s_wr_byte ##0 (locked && sp_sec) |=> !sda_oe && !wrote) // R12
		else $error("locked page write acked");
	AST_BUSY_START: assert property (stop_ev && wrote && !busy |=> s_hold_busy) // R5
		else $error("write cycle not started");
	AST_NO_CYCLE: assert property (stop_ev && !wrote && !busy |=> !busy) // R25
		else $error("refused write started a cycle");
	AST_PAGE_WRAP: assert property (mem_wr.we && !cur_special |=> arr_ptr[12:5] == $past(arr_ptr[12:5])) // R7
		else $error("page write left its page");
	AST_ARR_WRAP: assert property (tx_load && !cur_special && (arr_ptr == 13'h1fff) |=> arr_ptr == 13'h0000) // R18
		else $error("array read did not wrap");
	AST_UID_WRAP: assert property (tx_load && sp_uid && (uid_ptr == 4'hf) |=> uid_ptr == 4'h0) // R23
		else $error("unique id did not wrap");
	AST_CFG_READ: assert property (tx_load && sp_cfg |=> tx_byte == (cfg | CFG_UNUSED)) // R20
		else $error("config read value wrong");
	AST_LOCK_READ: assert property (tx_load && sp_lock |=> tx_byte[LOCK_STATUS_BIT] == locked) // R4
		else $error("lock status bit wrong");
	AST_SEL_HELD: assert property (wp |=> $stable(cfg[7:5])) // R15
		else $error("select bits changed under protect");

endmodule : sece_engine

`default_nettype wire

// [verif/sece_master.sv]
// Purpose: two-wire bus master model that drives scl and pulls sda
// Assumes: pull-up on sda, so a released line reads high
// Notes:   a bit lasts 16 sys_clk (64 ns), changes land on the falling edge
`timescale 1ns/1ps
`default_nettype none

module sece_master (
	input  wire logic sys_clk,
	input  wire logic sda,
	output var  logic scl,
	output var  logic sda_low
);
	// bus idle at time zero: scl high, sda released
	initial begin
		scl     = 1'b1;
		sda_low = 1'b0;
	end

	// wait n falling edges of the system clock
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : tick

	// start or repeated start: sda falls while scl is high
	task automatic start_c();
		sda_low = 1'b0;
		// the slave drops its ack about five clocks after scl falls; raising scl sooner makes a false stop
		tick(8);
		scl = 1'b1;
		tick(8);
		sda_low = 1'b1;
		tick(8);
		scl = 1'b0;
	endtask : start_c

	// stop: sda rises while scl is high, clock then stands still
	task automatic stop_c();
		tick(4);
		sda_low = 1'b1;
		tick(4);
		scl = 1'b1;
		tick(8);
		sda_low = 1'b0;
		tick(8);
	endtask : stop_c

	// one bit: data set mid low phase, sampled mid high phase
	task automatic bit_c(input logic b, output logic s);
		tick(4);
		sda_low = !b;
		tick(4);
		scl = 1'b1;
		tick(4);
		s = sda;
		tick(4);
		scl = 1'b0;
	endtask : bit_c

	// byte out msb first, then sample the slave acknowledge
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_c(b[i], s);
		end
		bit_c(1'b1, s);
		ack = !s;
	endtask : wr_byte

	// byte in msb first, then acknowledge or leave the line high
	task automatic rd_byte(input logic mack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_c(1'b1, d[i]);
		end
		bit_c(!mack, s);
	endtask : rd_byte
endmodule : sece_master

`default_nettype wire

// [verif/testbench.sv]
// Purpose: self-checking bench of the serial eeprom command engine
// Assumes: write time shortened to WR_CYC clocks
// Notes:   expected bytes follow from the address map and the bytes written
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import sece_pkg::*;

	localparam int           WR_CYC = 400;  // shortened internal_write_time
	localparam logic [127:0] UID    = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff; // arbitrary value

	logic       sys_clk;
	logic       rst;
	logic       scl;
	logic       m_low;
	logic       sda_out;
	logic       sda_oe;
	logic       write_busy;
	logic       page_locked;
	logic [7:0] config_value;
	logic       wp;
	logic       ds2;
	logic       ds1;
	logic       ds0;
	wire logic  sda;
	int         n_mismatch   = 0;
	int         total_checks = 0;
	logic [2:0] sel          = 3'h0;  // device select the bench addresses
	logic [7:0] uq[$];                // expected id stream

	// pull-up wins when nobody pulls the line low; the device pulls the line low while enabled and its sda_out is low
	assign sda = !(m_low || (sda_oe && !sda_out));

	sece_engine #(.WRITE_CYCLES(WR_CYC), .UNIQUE_ID(UID)) dut_u (
		.sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.write_busy(write_busy), .page_locked(page_locked), .config_value(config_value),
		.global_write_protect_bit(wp), .device_select_bit_2(ds2), .device_select_bit_1(ds1),
		.device_select_bit_0(ds0)
	);

	sece_master master_u (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(m_low));

	// 250 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// byte compare, also used for single bits
	task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk_byte

	task automatic chk_bit(input string nm, input logic e, input logic g);
		chk_byte(nm, {7'h0, e}, {7'h0, g});
	endtask : chk_bit

	// send one byte and compare the acknowledge
	task automatic send(input logic [7:0] b, input logic ea);
		logic a;
		master_u.wr_byte(b, a);
		chk_bit("ack", ea, a);
	endtask : send

	// write command: address bytes always acked, data acked as da says
	task automatic wr_cmd(input logic [3:0] hdr, input logic [7:0] hi, input logic [7:0] lo,
			input logic [7:0] d[$], input logic da);
		master_u.start_c();
		send({hdr, sel, 1'b0}, 1'b1);
		send(hi, 1'b1);
		send(lo, 1'b1);
		foreach (d[i]) send(d[i], da);
		master_u.stop_c();
	endtask : wr_cmd

	// dummy write then read; master acks all but the last byte
	task automatic rd_cmd(input logic [3:0] hdr, input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] e[$]);
		logic [7:0] g;
		master_u.start_c();
		send({hdr, sel, 1'b0}, 1'b1);
		send(hi, 1'b1);
		send(lo, 1'b1);
		master_u.start_c();
		send({hdr, sel, 1'b1}, 1'b1);
		foreach (e[i]) begin
			master_u.rd_byte(i != e.size() - 1, g);
			chk_byte("read", e[i], g);
		end
		master_u.stop_c();
	endtask : rd_cmd

	// address byte alone, expected to be refused
	task automatic probe(input logic [7:0] dev);
		master_u.start_c();
		send(dev, 1'b0);
		master_u.stop_c();
	endtask : probe

	// bounded wait for the internal write to finish
	task automatic wait_done();
		int n;
		n = 0;
		while (write_busy !== 1'b0 && n < 1000) begin
			@(negedge sys_clk);
			n++;
		end
		chk_bit("busy", 1'b0, write_busy);
	endtask : wait_done

	task automatic stop_test();
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	// watchdog: the tests need about 23k clocks, the limit is 50k
	initial begin
		#200000;
		n_mismatch++;
		stop_test();
	end

	// main sequence
	initial begin
		rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk) rst = 1'b0;
		repeat (4) @(negedge sys_clk);
		chk_byte("config", 8'h00, config_value);
		chk_byte("select", 8'h00, {5'h0, ds2, ds1, ds0});
		wr_cmd(HDR_ARRAY, 8'h01, 8'h23, '{8'h5a}, 1'b1);
		repeat (2) @(negedge sys_clk);
		chk_bit("busy", 1'b1, write_busy);
		probe({HDR_ARRAY, sel, 1'b1});
		wait_done();
		rd_cmd(HDR_ARRAY, 8'he1, 8'h23, '{8'h5a});
		wr_cmd(HDR_ARRAY, 8'h00, 8'h1e, '{8'ha1, 8'hb2, 8'hc3}, 1'b1);
		wait_done();
		rd_cmd(HDR_ARRAY, 8'h00, 8'h1f, '{8'hb2, 8'hff});
		rd_cmd(HDR_ARRAY, 8'h1f, 8'hff, '{8'hff, 8'hc3, 8'hff});
		wr_cmd(HDR_SPECIAL, 8'hf9, 8'hff, '{8'h63}, 1'b1);
		wait_done();
		wr_cmd(HDR_SPECIAL, 8'h00, 8'hc0, '{8'h11}, 1'b1);
		wait_done();
		rd_cmd(HDR_SPECIAL, 8'h00, 8'h3f, '{8'h63, 8'h11});
		for (int i = 0; i < 17; i++) uq.push_back(UID[127 - 8 * (i % 16) -: 8]);
		rd_cmd(HDR_SPECIAL, 8'h02, 8'hf0, uq);
		rd_cmd(HDR_SPECIAL, 8'h06, 8'h00, '{8'h1d, 8'h1d});
		rd_cmd(HDR_SPECIAL, 8'h04, 8'h00, '{8'h00});
		probe(8'h90);
		wr_cmd(HDR_SPECIAL, 8'h06, 8'h00, '{8'h20}, 1'b1);
		repeat (WR_CYC) @(negedge sys_clk);
		chk_byte("select", 8'h01, {5'h0, ds2, ds1, ds0});
		probe({HDR_ARRAY, 3'h0, 1'b0});
		sel = 3'h1;
		wr_cmd(HDR_SPECIAL, 8'h06, 8'h00, '{8'h22}, 1'b1);
		repeat (WR_CYC) @(negedge sys_clk);
		chk_bit("protect", 1'b1, wp);
		wr_cmd(HDR_ARRAY, 8'h00, 8'h00, '{8'h99}, 1'b0);
		repeat (2) @(negedge sys_clk);
		chk_bit("busy", 1'b0, write_busy);
		rd_cmd(HDR_ARRAY, 8'h00, 8'h00, '{8'hc3});
		wr_cmd(HDR_SPECIAL, 8'h06, 8'h00, '{8'he2}, 1'b0);
		wr_cmd(HDR_SPECIAL, 8'h06, 8'h00, '{8'h00}, 1'b1);
		repeat (WR_CYC) @(negedge sys_clk);
		chk_byte("config", 8'h20, config_value);
		wr_cmd(HDR_SPECIAL, 8'h04, 8'h00, '{8'h00}, 1'b0);
		wr_cmd(HDR_SPECIAL, 8'h04, 8'h00, '{8'hff}, 1'b1);
		wait_done();
		chk_bit("locked", 1'b1, page_locked);
		rd_cmd(HDR_SPECIAL, 8'h04, 8'h00, '{8'h02});
		wr_cmd(HDR_SPECIAL, 8'h00, 8'h05, '{8'h44}, 1'b0);
		repeat (2) @(negedge sys_clk);
		chk_bit("busy", 1'b0, write_busy);
		rd_cmd(HDR_SPECIAL, 8'h00, 8'h00, '{8'h11});
		stop_test();
	end
endmodule : testbench

`default_nettype wire
